// ===== verilog/opc_pkg.sv
// Purpose: Shared constants and carriers for the opportunistic performance control block.
// Assumes: Registers are reached by model-specific register accesses from the local processor.
// Notes: Register indices are word-sized register numbers, not byte addresses.
package opc_pkg;
  localparam int LP_IDX_W = 4;
  localparam int REG_W = 64;
  localparam int ADDR_W = 32;

  // Register numbers.
  localparam logic [ADDR_W-1:0] MISC_FEATURE_ADDR = 32'h0000_01a0;
  localparam logic [ADDR_W-1:0] PERF_LEVEL_STATUS_ADDR = 32'h0000_0198;
  localparam logic [ADDR_W-1:0] PERF_TARGET_CONTROL_ADDR = 32'h0000_0199;
  localparam logic [ADDR_W-1:0] FIXED_RATE_ADDR = 32'h0000_00e7;
  localparam logic [ADDR_W-1:0] ACTUAL_PERF_ADDR = 32'h0000_00e8;
  localparam logic [ADDR_W-1:0] CORE_TICK_ADDR = 32'h0000_030a;
  localparam logic [ADDR_W-1:0] REF_TICK_ADDR = 32'h0000_030b;
  localparam logic [ADDR_W-1:0] PLATFORM_INFO_ADDR = 32'h0000_00ce;
  localparam logic [ADDR_W-1:0] TIMESTAMP_ADDR = 32'h0000_0010;
  localparam logic [ADDR_W-1:0] COUNTER_FREEZE_ADDR = 32'h0000_01d9;

  // Field positions.
  localparam int OPP_DISABLE_BIT = 38;
  localparam int DISENGAGE_BIT = 32;
  localparam int FREEZE_MGMT_BIT = 14;
  localparam int BASE_RATIO_LSB = 8;
  localparam int BASE_RATIO_W = 8;
  localparam int STATUS_POINT_W = 16;
  localparam int ID_OPP_ENABLED_BIT = 1;

  // Identification query and counter read selectors.
  localparam logic [31:0] POWER_LEAF = 32'h0000_0006;
  localparam logic [31:0] SEL_CORE_TICK = 32'h4000_0001;
  localparam logic [31:0] SEL_REF_TICK = 32'h4000_0002;

  // Reset values.
  localparam logic [REG_W-1:0] MISC_RESET_BASE = 64'h0000_0000_0000_0000;
  localparam logic [REG_W-1:0] ZERO_64 = 64'h0000_0000_0000_0000;

  // Counter slots inside one logical processor.
  localparam int CNT_NUM = 4;
  localparam int CNT_ACTUAL = 0;
  localparam int CNT_FIXED_RATE = 1;
  localparam int CNT_CORE = 2;
  localparam int CNT_REF = 3;

  typedef struct packed {
    logic valid;
    logic write;
    logic [LP_IDX_W-1:0] lp;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
  } opc_msr_req_s;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [REG_W-1:0] rdata;
  } opc_msr_rsp_s;

  typedef struct packed {
    logic valid;
    logic [LP_IDX_W-1:0] lp;
    logic [31:0] sel;
  } opc_query_req_s;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [REG_W-1:0] data;
  } opc_query_rsp_s;
endpackage

// ===== verilog/opc_lp_counters.sv
// Purpose: Activity counters of one logical processor.
// Assumes: Tick strobes come from clock logic on the same clock.
// Notes: A software write wins over a count in the same cycle.
`timescale 1ns/1ps
module opc_lp_counters #(
  parameter int CNT_W = 64
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic freeze,
  input wire logic unhalted,
  input wire logic core_tick,
  input wire logic ref_tick,
  input wire logic [opc_pkg::CNT_NUM-1:0] wr_en,
  input wire logic [CNT_W-1:0] wdata,
  output logic [opc_pkg::CNT_NUM-1:0][CNT_W-1:0] cnt_q
);
  logic [opc_pkg::CNT_NUM-1:0][CNT_W-1:0] cnt_d;
  logic run;
  logic core_inc;
  logic ref_inc;
  logic ratio_wrap;

  assign run = unhalted & ~freeze;
  assign core_inc = run & core_tick;
  assign ref_inc = run & ref_tick;
  // When either ratio counter would wrap, both restart so the ratio stays meaningful.
  assign ratio_wrap = (core_inc & (&cnt_q[opc_pkg::CNT_ACTUAL]))
                    | (ref_inc & (&cnt_q[opc_pkg::CNT_FIXED_RATE]));

  always_comb begin
    cnt_d = cnt_q;
    if (ratio_wrap) begin
      cnt_d[opc_pkg::CNT_ACTUAL] = '0;
      cnt_d[opc_pkg::CNT_FIXED_RATE] = '0;
    end else begin
      cnt_d[opc_pkg::CNT_ACTUAL] = cnt_q[opc_pkg::CNT_ACTUAL] + CNT_W'(core_inc);
      cnt_d[opc_pkg::CNT_FIXED_RATE] = cnt_q[opc_pkg::CNT_FIXED_RATE] + CNT_W'(ref_inc);
    end
    cnt_d[opc_pkg::CNT_CORE] = cnt_q[opc_pkg::CNT_CORE] + CNT_W'(core_inc);
    cnt_d[opc_pkg::CNT_REF] = cnt_q[opc_pkg::CNT_REF] + CNT_W'(ref_inc);
    for (int i = 0; i < opc_pkg::CNT_NUM; i++) begin
      if (wr_en[i]) begin
        cnt_d[i] = wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // opc_lp_counters

// ===== verilog/opc_perf_ctrl.sv
// Purpose: Package-wide and per-processor control of opportunistic above-base operation.
// Assumes: Model-specific register, identification query and counter read requests come
// from the local core on clk; status inputs are from the same clock domain.
// Notes: Every request is answered one cycle after it is taken.
`timescale 1ns/1ps
module opc_perf_ctrl #(
  parameter int NUM_LP = 2,
  parameter bit HW_SUPPORT = 1'b1,
  parameter logic [7:0] BASE_RATIO = 8'h10
) (
  input wire logic clk,
  input wire logic srst,
  input wire opc_pkg::opc_msr_req_s msr_req,
  output opc_pkg::opc_msr_rsp_s msr_rsp,
  input wire opc_pkg::opc_query_req_s id_req,
  output opc_pkg::opc_query_rsp_s id_rsp,
  input wire opc_pkg::opc_query_req_s pmc_req,
  output opc_pkg::opc_query_rsp_s pmc_rsp,
  input wire logic [NUM_LP-1:0] lp_unhalted,
  input wire logic [NUM_LP-1:0] lp_core_tick,
  input wire logic [NUM_LP-1:0] lp_ref_tick,
  input wire logic [NUM_LP-1:0][opc_pkg::STATUS_POINT_W-1:0] lp_op_point,
  input wire logic mgmt_mode_active,
  input wire logic headroom_ok,
  input wire logic [NUM_LP-1:0] criteria_ok,
  output logic [NUM_LP-1:0] opp_eligible,
  output logic [NUM_LP-1:0] opp_engaged
);
  localparam int W = opc_pkg::REG_W;

  function automatic logic lp_in_range(input logic [opc_pkg::LP_IDX_W-1:0] lp);
    lp_in_range = (32'(lp) < NUM_LP);
  endfunction

  function automatic logic [W-1:0] status_word(input logic [opc_pkg::STATUS_POINT_W-1:0] pt);
    status_word = {{(W - opc_pkg::STATUS_POINT_W){1'b0}}, pt};
  endfunction

  // Shared and per-processor state.
  logic [W-1:0] misc_q;
  logic [W-1:0] misc_d;
  logic [NUM_LP-1:0][W-1:0] target_ctl_q;
  logic [NUM_LP-1:0][W-1:0] target_ctl_d;
  logic freeze_en_q;
  logic freeze_en_d;
  logic [W-1:0] tsc_q;
  logic [W-1:0] tsc_d;
  logic [NUM_LP-1:0][opc_pkg::CNT_NUM-1:0][W-1:0] cnt;
  logic [NUM_LP-1:0][opc_pkg::CNT_NUM-1:0] cnt_wr;

  // Registered outputs.
  opc_pkg::opc_msr_rsp_s msr_rsp_q;
  opc_pkg::opc_msr_rsp_s msr_rsp_d;
  opc_pkg::opc_query_rsp_s id_rsp_q;
  opc_pkg::opc_query_rsp_s id_rsp_d;
  opc_pkg::opc_query_rsp_s pmc_rsp_q;
  opc_pkg::opc_query_rsp_s pmc_rsp_d;
  logic [NUM_LP-1:0] eligible_q;
  logic [NUM_LP-1:0] eligible_d;
  logic [NUM_LP-1:0] engaged_q;
  logic [NUM_LP-1:0] engaged_d;

  // Decode.
  // Register numbers are compared whole, so no alias of a register answers.
  wire msr_lp_ok = lp_in_range(msr_req.lp);
  wire msr_wr = msr_req.valid & msr_req.write & msr_lp_ok;
  wire hit_misc = (msr_req.addr == opc_pkg::MISC_FEATURE_ADDR);
  wire hit_status = (msr_req.addr == opc_pkg::PERF_LEVEL_STATUS_ADDR);
  wire hit_target = (msr_req.addr == opc_pkg::PERF_TARGET_CONTROL_ADDR);
  wire hit_fixed = (msr_req.addr == opc_pkg::FIXED_RATE_ADDR);
  wire hit_actual = (msr_req.addr == opc_pkg::ACTUAL_PERF_ADDR);
  wire hit_core = (msr_req.addr == opc_pkg::CORE_TICK_ADDR);
  wire hit_ref = (msr_req.addr == opc_pkg::REF_TICK_ADDR);
  wire hit_plat = (msr_req.addr == opc_pkg::PLATFORM_INFO_ADDR);
  wire hit_tsc = (msr_req.addr == opc_pkg::TIMESTAMP_ADDR);
  wire hit_frz = (msr_req.addr == opc_pkg::COUNTER_FREEZE_ADDR);
  wire hit_ro = hit_status | hit_plat;
  wire hit_any = hit_misc | hit_status | hit_target | hit_fixed | hit_actual
               | hit_core | hit_ref | hit_plat | hit_tsc | hit_frz;
  wire opp_enabled = HW_SUPPORT & ~misc_q[opc_pkg::OPP_DISABLE_BIT];
  wire freeze = freeze_en_q & mgmt_mode_active;
  wire [W-1:0] plat_word = {{(W - opc_pkg::BASE_RATIO_LSB - opc_pkg::BASE_RATIO_W){1'b0}},
                            BASE_RATIO, {opc_pkg::BASE_RATIO_LSB{1'b0}}};

  // One counter set and one control word per logical processor.
  genvar g;
  generate
    for (g = 0; g < NUM_LP; g++) begin : g_lp
      wire lp_sel = msr_wr & (32'(msr_req.lp) == g);
      assign cnt_wr[g][opc_pkg::CNT_ACTUAL] = lp_sel & hit_actual;
      assign cnt_wr[g][opc_pkg::CNT_FIXED_RATE] = lp_sel & hit_fixed;
      assign cnt_wr[g][opc_pkg::CNT_CORE] = lp_sel & hit_core;
      assign cnt_wr[g][opc_pkg::CNT_REF] = lp_sel & hit_ref;

      opc_lp_counters #(
        .CNT_W(W)
      ) u_cnt (
        .clk(clk),
        .srst(srst),
        .freeze(freeze),
        .unhalted(lp_unhalted[g]),
        .core_tick(lp_core_tick[g]),
        .ref_tick(lp_ref_tick[g]),
        .wr_en(cnt_wr[g]),
        .wdata(msr_req.wdata),
        .cnt_q(cnt[g])
      );

      assign target_ctl_d[g] = (lp_sel & hit_target) ? msr_req.wdata : target_ctl_q[g];
      assign eligible_d[g] = opp_enabled & ~target_ctl_q[g][opc_pkg::DISENGAGE_BIT];
      assign engaged_d[g] = eligible_q[g] & headroom_ok & criteria_ok[g];
    end
  endgenerate

  // The whole word is writable; only the disable bit acts inside this block.
  // Shared disable bit.
  assign misc_d = (msr_wr & hit_misc) ? msr_req.wdata : misc_q;
  assign freeze_en_d = (msr_wr & hit_frz) ? msr_req.wdata[opc_pkg::FREEZE_MGMT_BIT] : freeze_en_q;
  // It never pauses for halt or management mode, so idle time can be measured against it.
  // Timestamp runs always.
  assign tsc_d = (msr_wr & hit_tsc) ? msr_req.wdata : tsc_q + W'(1);

  // Register read and write answers. Writes to read-only or unknown registers fault.
  always_comb begin
    msr_rsp_d = '0;
    msr_rsp_d.valid = msr_req.valid;
    if (!msr_req.valid) begin
      msr_rsp_d.valid = 1'b0;
    end else if (!msr_lp_ok || !hit_any) begin
      msr_rsp_d.fault = 1'b1;
    end else if (msr_req.write) begin
      msr_rsp_d.fault = hit_ro;
    end else if (hit_misc) begin
      msr_rsp_d.rdata = misc_q;
    end else if (hit_status) begin
      msr_rsp_d.rdata = status_word(lp_op_point[msr_req.lp]);
    end else if (hit_target) begin
      msr_rsp_d.rdata = target_ctl_q[msr_req.lp];
    end else if (hit_fixed) begin
      msr_rsp_d.rdata = cnt[msr_req.lp][opc_pkg::CNT_FIXED_RATE];
    end else if (hit_actual) begin
      msr_rsp_d.rdata = cnt[msr_req.lp][opc_pkg::CNT_ACTUAL];
    end else if (hit_core) begin
      msr_rsp_d.rdata = cnt[msr_req.lp][opc_pkg::CNT_CORE];
    end else if (hit_ref) begin
      msr_rsp_d.rdata = cnt[msr_req.lp][opc_pkg::CNT_REF];
    end else if (hit_plat) begin
      msr_rsp_d.rdata = plat_word;
    end else if (hit_tsc) begin
      msr_rsp_d.rdata = tsc_q;
    end else begin
      msr_rsp_d.rdata[opc_pkg::FREEZE_MGMT_BIT] = freeze_en_q;
    end
  end

  // Identification query; leaves other than the power leaf read zero.
  always_comb begin
    id_rsp_d = '0;
    id_rsp_d.valid = id_req.valid;
    if (!id_req.valid) begin
      id_rsp_d.valid = 1'b0;
    end else if (!lp_in_range(id_req.lp)) begin
      id_rsp_d.fault = 1'b1;
    end else if (id_req.sel == opc_pkg::POWER_LEAF) begin
      id_rsp_d.data[opc_pkg::ID_OPP_ENABLED_BIT] = opp_enabled;
    end
  end

  // Counter read instruction.
  // Unknown selectors fault rather than read zero, so a typo never looks like an idle counter.
  always_comb begin
    pmc_rsp_d = '0;
    pmc_rsp_d.valid = pmc_req.valid;
    if (!pmc_req.valid) begin
      pmc_rsp_d.valid = 1'b0;
    end else if (!lp_in_range(pmc_req.lp)) begin
      pmc_rsp_d.fault = 1'b1;
    end else if (pmc_req.sel == opc_pkg::SEL_CORE_TICK) begin
      pmc_rsp_d.data = cnt[pmc_req.lp][opc_pkg::CNT_CORE];
    end else if (pmc_req.sel == opc_pkg::SEL_REF_TICK) begin
      pmc_rsp_d.data = cnt[pmc_req.lp][opc_pkg::CNT_REF];
    end else begin
      pmc_rsp_d.fault = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      misc_q <= opc_pkg::MISC_RESET_BASE | (W'(HW_SUPPORT) << opc_pkg::OPP_DISABLE_BIT);
    end else begin
      misc_q <= misc_d;
    end
  end

  // Each processor keeps its own word, so a disengage never reaches a sibling.
  always_ff @(posedge clk) begin
    if (srst) begin
      target_ctl_q <= '0;
    end else begin
      target_ctl_q <= target_ctl_d;
    end
  end

  // Freeze starts off so counters run until software asks otherwise.
  always_ff @(posedge clk) begin
    if (srst) begin
      freeze_en_q <= 1'b0;
    end else begin
      freeze_en_q <= freeze_en_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tsc_q <= opc_pkg::ZERO_64;
    end else begin
      tsc_q <= tsc_d;
    end
  end

  // Answers leave flip-flops, which costs one cycle of latency on every request.
  always_ff @(posedge clk) begin
    if (srst) begin
      msr_rsp_q <= '0;
    end else begin
      msr_rsp_q <= msr_rsp_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      id_rsp_q <= '0;
    end else begin
      id_rsp_q <= id_rsp_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pmc_rsp_q <= '0;
    end else begin
      pmc_rsp_q <= pmc_rsp_d;
    end
  end

  // Eligibility lags a register write request by two cycles and engagement by one more.
  always_ff @(posedge clk) begin
    if (srst) begin
      eligible_q <= '0;
    end else begin
      eligible_q <= eligible_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      engaged_q <= '0;
    end else begin
      engaged_q <= engaged_d;
    end
  end

  assign msr_rsp = msr_rsp_q;
  assign id_rsp = id_rsp_q;
  assign pmc_rsp = pmc_rsp_q;
  assign opp_eligible = eligible_q;
  assign opp_engaged = engaged_q;
endmodule // opc_perf_ctrl

// ===== bench/opc_perf_ctrl_assertions.sv
// Purpose: Concurrent checks on the opportunistic performance control ports.
// Assumes: One clock and a synchronous active-high reset.
// Notes: Every request is answered on the edge after it is taken.
`timescale 1ns/1ps
module opc_perf_ctrl_assertions #(
  parameter int NUM_LP = 2,
  parameter logic [7:0] BASE_RATIO = 8'h10
) (
  input wire logic clk,
  input wire logic srst,
  input wire opc_pkg::opc_msr_req_s msr_req,
  input wire opc_pkg::opc_msr_rsp_s msr_rsp,
  input wire opc_pkg::opc_query_req_s id_req,
  input wire opc_pkg::opc_query_rsp_s id_rsp,
  input wire opc_pkg::opc_query_req_s pmc_req,
  input wire opc_pkg::opc_query_rsp_s pmc_rsp,
  input wire logic headroom_ok,
  input wire logic [NUM_LP-1:0] criteria_ok,
  input wire logic [NUM_LP-1:0] opp_eligible,
  input wire logic [NUM_LP-1:0] opp_engaged
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire rd_ok = msr_req.valid && !msr_req.write && (msr_req.lp < NUM_LP);
  wire pmc_ok = pmc_req.valid && (pmc_req.lp < NUM_LP);

  a_id_leaf_bit: assert property (
    id_req.valid && id_req.lp < NUM_LP && id_req.sel == opc_pkg::POWER_LEAF
    |=> id_rsp.valid && !id_rsp.fault && id_rsp.data[63:2] == 62'h0 && !id_rsp.data[0])
    else $error("leaf six answer malformed");
  a_status_no_write: assert property (
    msr_req.valid && msr_req.write && msr_req.addr == opc_pkg::PERF_LEVEL_STATUS_ADDR
    |=> msr_rsp.valid && msr_rsp.fault)
    else $error("status write not refused");
  a_status_hides_bit: assert property (
    rd_ok && msr_req.addr == opc_pkg::PERF_LEVEL_STATUS_ADDR |=> !msr_rsp.rdata[32])
    else $error("status shows disengage bit");
  a_platform_ratio: assert property (
    rd_ok && msr_req.addr == opc_pkg::PLATFORM_INFO_ADDR |=> !msr_rsp.fault && msr_rsp.rdata[15:8] == BASE_RATIO)
    else $error("base ratio wrong");
  a_core_sel_ok: assert property (
    pmc_ok && pmc_req.sel == opc_pkg::SEL_CORE_TICK |=> pmc_rsp.valid && !pmc_rsp.fault)
    else $error("core tick selector refused");
  a_ref_sel_ok: assert property (
    pmc_ok && pmc_req.sel == opc_pkg::SEL_REF_TICK |=> pmc_rsp.valid && !pmc_rsp.fault)
    else $error("reference tick selector refused");
  a_engage_gate: assert property (
    opp_engaged == ($past(opp_eligible) & {NUM_LP{$past(headroom_ok)}} & $past(criteria_ok)))
    else $error("engaged without eligibility and headroom");
  a_eligible_cause: assert property (
    opp_eligible != $past(opp_eligible) |-> $past(msr_req.valid && msr_req.write, 2))
    else $error("eligibility moved without a write");
  a_lp_range: assert property (
    msr_req.valid && msr_req.lp >= NUM_LP |=> msr_rsp.valid && msr_rsp.fault)
    else $error("bad processor index accepted");

  c_write: cover property (msr_req.valid && msr_req.write);
  c_engaged: cover property (|opp_engaged);
  c_pmc: cover property (pmc_rsp.valid && !pmc_rsp.fault);
endmodule // opc_perf_ctrl_assertions

// ===== bench/testbench.sv
// Purpose: Self-checking bench for opc_perf_ctrl.
// Assumes: Default parameters; inputs change on rising edges.
// Notes: Ticks are held as levels for a counted number of edges.
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] MISC = opc_pkg::MISC_FEATURE_ADDR;
  localparam logic [31:0] CTL = opc_pkg::PERF_TARGET_CONTROL_ADDR;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mgmt = 1'b0;
  logic hr = 1'b1;
  logic [1:0] unh = 2'b11, ct = 2'b00, rt = 2'b00, crit = 2'b11, elig, eng;
  logic [1:0][15:0] opt = {16'h0000, 16'h00ab};
  opc_pkg::opc_msr_req_s mreq = '0;
  opc_pkg::opc_msr_rsp_s mrsp;
  opc_pkg::opc_query_req_s ireq = '0, preq = '0;
  opc_pkg::opc_query_rsp_s irsp, prsp;
  logic [63:0] rd, t0;
  logic flt;
  int fail_count = 0;
  int n_compared = 0;

  opc_perf_ctrl #(.NUM_LP(2), .HW_SUPPORT(1'b1), .BASE_RATIO(8'h10)) u_dut (.clk(clk), .srst(srst),
    .msr_req(mreq), .msr_rsp(mrsp), .id_req(ireq), .id_rsp(irsp), .pmc_req(preq), .pmc_rsp(prsp),
    .lp_unhalted(unh), .lp_core_tick(ct), .lp_ref_tick(rt), .lp_op_point(opt), .mgmt_mode_active(mgmt),
    .headroom_ok(hr), .criteria_ok(crit), .opp_eligible(elig), .opp_engaged(eng));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic msr(input logic [3:0] lp, input logic [31:0] a, input logic w, input logic [63:0] wd);
    @(posedge clk);
    mreq <= '{valid: 1'b1, write: w, lp: lp, addr: a, wdata: wd};
    @(posedge clk);
    mreq.valid <= 1'b0;
    #1;
    rd = mrsp.rdata;
    flt = mrsp.fault;
  endtask

  task automatic qry(input logic p, input logic [3:0] lp, input logic [31:0] s);
    @(posedge clk);
    if (p) begin
      preq <= '{valid: 1'b1, lp: lp, sel: s};
    end else begin
      ireq <= '{valid: 1'b1, lp: lp, sel: s};
    end
    @(posedge clk);
    preq.valid <= 1'b0;
    ireq.valid <= 1'b0;
    #1;
    rd = p ? prsp.data : irsp.data;
    flt = p ? prsp.fault : irsp.fault;
  endtask

  task automatic tick(input int n, input logic [1:0] c, input logic [1:0] r, input logic [1:0] u, input logic m);
    @(posedge clk);
    ct <= c;
    rt <= r;
    unh <= u;
    mgmt <= m;
    repeat (n) @(posedge clk);
    ct <= 2'b00;
    rt <= 2'b00;
  endtask

  task automatic wt();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic rmw(input logic s);
    msr(4'h0, CTL, 1'b0, 64'h0);
    msr(4'h0, CTL, 1'b1, {rd[63:33], s, rd[31:0]});
  endtask

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    msr(4'h0, MISC, 1'b0, 64'h0);
    chk(rd, opc_pkg::MISC_RESET_BASE | 64'h40_0000_0000, "misc reset");
    qry(1'b0, 4'h0, opc_pkg::POWER_LEAF);
    chk(rd, 64'h0, "leaf six while disabled");
    chk(elig, 2'b00, "eligible while disabled");
    msr(4'h1, MISC, 1'b1, 64'h0);
    qry(1'b0, 4'h0, opc_pkg::POWER_LEAF);
    chk(rd, 64'h2, "leaf six enabled");
    wt();
    chk(elig, 2'b11, "shared enable");
    msr(4'h0, CTL, 1'b1, 64'h1234);
    rmw(1'b1);
    msr(4'h0, CTL, 1'b0, 64'h0);
    chk(rd, 64'h1_0000_1234, "control readback");
    msr(4'h0, opc_pkg::PERF_LEVEL_STATUS_ADDR, 1'b0, 64'h0);
    chk(rd, 64'h00ab, "status value");
    wt();
    chk(elig, 2'b10, "own disengage");
    chk(eng, 2'b10, "engaged set");
    @(posedge clk);
    crit <= 2'b01;
    wt();
    chk(eng, 2'b00, "criteria gate");
    rmw(1'b0);
    wt();
    chk(elig, 2'b11, "re-engaged");
    msr(4'h0, opc_pkg::CORE_TICK_ADDR, 1'b1, 64'h10);
    tick(5, 2'b01, 2'b00, 2'b11, 1'b0);
    tick(3, 2'b00, 2'b01, 2'b11, 1'b0);
    tick(4, 2'b01, 2'b01, 2'b10, 1'b0);
    qry(1'b1, 4'h0, opc_pkg::SEL_CORE_TICK);
    chk(rd, 64'h15, "core ticks");
    qry(1'b1, 4'h0, opc_pkg::SEL_REF_TICK);
    chk(rd, 64'h3, "reference ticks");
    msr(4'h0, opc_pkg::COUNTER_FREEZE_ADDR, 1'b1, 64'h4000);
    tick(4, 2'b01, 2'b01, 2'b11, 1'b1);
    tick(2, 2'b01, 2'b00, 2'b11, 1'b0);
    qry(1'b1, 4'h0, opc_pkg::SEL_CORE_TICK);
    chk(rd, 64'h17, "frozen in management mode");
    msr(4'h1, opc_pkg::ACTUAL_PERF_ADDR, 1'b1, 64'h0);
    msr(4'h1, opc_pkg::FIXED_RATE_ADDR, 1'b1, 64'h0);
    tick(6, 2'b10, 2'b10, 2'b11, 1'b0);
    tick(3, 2'b10, 2'b00, 2'b11, 1'b0);
    msr(4'h1, opc_pkg::ACTUAL_PERF_ADDR, 1'b0, 64'h0);
    chk(rd, 64'h9, "actual count");
    msr(4'h1, opc_pkg::FIXED_RATE_ADDR, 1'b0, 64'h0);
    chk(rd, 64'h6, "fixed-rate count");
    tick(1, 2'b00, 2'b00, 2'b00, 1'b0);
    msr(4'h0, opc_pkg::TIMESTAMP_ADDR, 1'b0, 64'h0);
    t0 = rd;
    msr(4'h0, opc_pkg::TIMESTAMP_ADDR, 1'b0, 64'h0);
    chk(rd - t0, 64'h2, "timestamp while idle");
    msr(4'h0, opc_pkg::PLATFORM_INFO_ADDR, 1'b0, 64'h0);
    chk(rd[15:8], 64'h10, "base ratio");
    msr(4'h0, opc_pkg::PERF_LEVEL_STATUS_ADDR, 1'b1, 64'h1);
    chk(flt, 64'h1, "status write");
    msr(4'h2, MISC, 1'b0, 64'h0);
    chk(flt, 64'h1, "processor index");
    qry(1'b1, 4'h0, 32'h4000_0003);
    chk(flt, 64'h1, "bad selector");
    finish_test();
  end

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule // testbench

bind opc_perf_ctrl opc_perf_ctrl_assertions #(.NUM_LP(NUM_LP), .BASE_RATIO(BASE_RATIO)) u_chk (.clk(clk),
  .srst(srst), .msr_req(msr_req), .msr_rsp(msr_rsp), .id_req(id_req), .id_rsp(id_rsp), .pmc_req(pmc_req),
  .pmc_rsp(pmc_rsp), .headroom_ok(headroom_ok), .criteria_ok(criteria_ok), .opp_eligible(opp_eligible),
  .opp_engaged(opp_engaged));
